// File: hotflag_timer_and_status.v
// hot-input duration timer, event status registers and alert gating
//
// Operation
// - upper seven bits time hot assertion
// - bit 0 sets on hot assertion
// - reading hot-time register clears bit 0
// - past 45.52 ms bit 0 joins count
// - each count step is 22.76 ms
// - fan stall flags in status bits 0,1
// - no stall flag while drive off
// - measurement limit flags in bits 2..6
// - limit flags clear on read once gone
// - status bit 7 ORs second status
// - second status bit 0 over-temperature
// - over-temperature clears itself below hysteresis
// - bit 1 sets past hot-time limit
// - diode faults in bits 2 and 3
// - thermistor faults in bits 4 and 5
// - second status bits 6,7 read zero
// - mask bits block alert, keep flags; masked second-status flags still alert via unmasked bit 7
// - zero limit flags hot immediately
`timescale 1ns/1ps
`include "hotflag_consts.vh"
module hotflag_timer_and_status #(
	parameter TICK_CYCLES = `HOT_TICK_CYCLES,
	parameter TICK_WIDTH = 22
) (
	input wire clock,
	input wire rst_n,
	// register access port
	input wire [7:0] regAddr,
	input wire regRdEn,
	input wire regWrEn,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData,
	// monitor conditions from the measurement side
	input wire processorHotInputN,
	input wire hotPinIsInput,
	input wire firstFanSlow,
	input wire secondFanSlow,
	input wire firstFanDriveOff,
	input wire secondFanDriveOff,
	input wire localOutOfLimit,
	input wire firstRemoteOutOfLimit,
	input wire supplyOutOfLimit,
	input wire secondAnalogOutOfLimit,
	input wire firstAnalogOutOfLimit,
	input wire overtempExceeded,
	input wire overtempBelowHyst,
	input wire firstDiodeFault,
	input wire secondDiodeFault,
	input wire firstThermistorFault,
	input wire secondThermistorFault,
	// active-low alert level
	output reg alertN
);
	// largest reportable duration; the count sticks here
	localparam [7:0] COUNT_MAX = 8'hFF;
	// steps before the full count shows, cut to the register width on purpose
	localparam integer REPORT_INT = `HOT_REPORT_TICKS;
	localparam [7:0] REPORT_TICKS = REPORT_INT[7:0];

	// host-written control registers
	reg [7:0] maskFirst_r;
	reg [7:0] maskSecond_r;
	reg [7:0] hotLimit_r;

	// hot-time timer state
	reg hotPrev_r;
	reg assertFlag_r;
	reg [7:0] durCount_r;
	wire hotActive;
	wire hotRise;
	wire hotTick;
	wire [7:0] hotTimeValue;

	// status flags and read strobes
	wire [6:0] firstFlags;
	wire [5:0] secondFlags;
	reg overtemp_r;
	wire [7:0] statusFirst;
	wire [7:0] statusSecond;
	wire readHotTime;
	wire readFirst;
	wire readSecond;
	wire [6:0] firstSet;
	wire [6:0] firstHold;
	wire [5:1] secondSet;
	wire [5:1] secondHold;
	wire hotLimitReached;
	reg [7:0] rdMux;

	// the shared pin only times when configured as the hot input
	assign hotActive = hotPinIsInput & ~processorHotInputN;
	assign hotRise = hotActive & ~hotPrev_r;

	// read strobes; a read has its side effect in the cycle it is taken
	assign readHotTime = regRdEn && (regAddr == `OFS_HOT_ASSERTION_TIME);
	assign readFirst = regRdEn && (regAddr == `OFS_EVENT_STATUS_FIRST);
	assign readSecond = regRdEn && (regAddr == `OFS_EVENT_STATUS_SECOND);

	hot_tick_divider #(
		.CYCLES(TICK_CYCLES),
		.WIDTH(TICK_WIDTH)
	) u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.run(hotActive),
		.tick(hotTick)
	);

	// previous level of the hot input for edge detection
	// resets to the idle level so no false rise follows reset
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hotPrev_r <= 1'b0;
		end else begin
			hotPrev_r <= hotActive;
		end
	end

	// duration counting
	// restart on every new assertion; value holds after release for reading
	// count and flag are kept apart so a read can clear the flag alone
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			durCount_r <= `RST_HOT_ASSERTION_TIME;
		end else if (hotRise) begin
			durCount_r <= 8'h00;
		end else if (hotActive && hotTick && (durCount_r != COUNT_MAX)) begin
			durCount_r <= durCount_r + 8'h01;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			assertFlag_r <= 1'b0;
		end else if (hotRise) begin
			assertFlag_r <= 1'b1;
		end else if (readHotTime) begin
			assertFlag_r <= 1'b0;
		end
	end

	// count takes whole register
	// below the report threshold only the flag shows, upper bits read zero
	assign hotTimeValue = (durCount_r >= REPORT_TICKS) ? durCount_r :
		{7'h00, assertFlag_r};

	// hot-time limit compare
	// a nonzero limit below 0xFF fires one step after the count reaches it; the count never passes 0xFF
	assign hotLimitReached = hotActive &&
		((hotLimit_r == 8'h00) || (durCount_r > hotLimit_r));

	assign firstSet[`S1_SECOND_FAN] = secondFanSlow & ~secondFanDriveOff;
	assign firstSet[`S1_FIRST_FAN] = firstFanSlow & ~firstFanDriveOff;
	assign firstSet[`S1_LOCAL] = localOutOfLimit;
	assign firstSet[`S1_FIRST_REMOTE] = firstRemoteOutOfLimit;
	assign firstSet[`S1_SUPPLY] = supplyOutOfLimit;
	assign firstSet[`S1_SECOND_ANALOG] = secondAnalogOutOfLimit;
	assign firstSet[`S1_FIRST_ANALOG] = firstAnalogOutOfLimit;

	// hold while fault live
	// fan flags have no hold, only a live stall keeps them over a read; measurement flags need the fault gone
	assign firstHold[`S1_SECOND_FAN] = 1'b0;
	assign firstHold[`S1_FIRST_FAN] = 1'b0;
	assign firstHold[`S1_LOCAL] = localOutOfLimit;
	assign firstHold[`S1_FIRST_REMOTE] = firstRemoteOutOfLimit;
	assign firstHold[`S1_SUPPLY] = supplyOutOfLimit;
	assign firstHold[`S1_SECOND_ANALOG] = secondAnalogOutOfLimit;
	assign firstHold[`S1_FIRST_ANALOG] = firstAnalogOutOfLimit;

	// second status events; each clears on read only once its cause is gone
	assign secondSet[`S2_HOT_TIME] = hotLimitReached;
	assign secondSet[`S2_FIRST_DIODE] = firstDiodeFault;
	assign secondSet[`S2_SECOND_DIODE] = secondDiodeFault;
	assign secondSet[`S2_FIRST_THERMISTOR] = firstThermistorFault;
	assign secondSet[`S2_SECOND_THERMISTOR] = secondThermistorFault;
	assign secondHold[`S2_HOT_TIME] = hotActive;
	assign secondHold[`S2_FIRST_DIODE] = firstDiodeFault;
	assign secondHold[`S2_SECOND_DIODE] = secondDiodeFault;
	assign secondHold[`S2_FIRST_THERMISTOR] = firstThermistorFault;
	assign secondHold[`S2_SECOND_THERMISTOR] = secondThermistorFault;

	// sticky cells for the first status register
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_first
			sticky_flag_cell u_cell (
				.clock(clock),
				.rst_n(rst_n),
				.setEvent(firstSet[gi]),
				.clearRead(readFirst),
				.holdCond(firstHold[gi]),
				.flag(firstFlags[gi])
			);
		end
		// second status cells for bits 1..5; bit 0 clears by itself
		for (gi = 1; gi < 6; gi = gi + 1) begin : g_second
			sticky_flag_cell u_cell (
				.clock(clock),
				.rst_n(rst_n),
				.setEvent(secondSet[gi]),
				.clearRead(readSecond),
				.holdCond(secondHold[gi]),
				.flag(secondFlags[gi])
			);
		end
	endgenerate

	// self clear below hysteresis
	// reads do not touch this flag; only the temperature clears it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overtemp_r <= 1'b0;
		end else if (overtempExceeded) begin
			overtemp_r <= 1'b1;
		end else if (overtempBelowHyst) begin
			overtemp_r <= 1'b0;
		end
	end
	assign secondFlags[`S2_OVERTEMP] = overtemp_r;

	assign statusSecond = {2'b00, secondFlags};
	assign statusFirst = {(|secondFlags), firstFlags};

	// host writes to the limit and mask registers
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			maskFirst_r <= `RST_EVENT_MASK;
			maskSecond_r <= `RST_EVENT_MASK;
			hotLimit_r <= `RST_HOT_TIME_LIMIT;
		end else if (regWrEn) begin
			case (regAddr)
				`OFS_EVENT_MASK_FIRST: begin
					maskFirst_r <= regWrData;
				end
				`OFS_EVENT_MASK_SECOND: begin
					// upper bits have no flag behind them
					maskSecond_r <= {2'b00, regWrData[5:0]};
				end
				`OFS_HOT_TIME_LIMIT: begin
					hotLimit_r <= regWrData;
				end
				default: begin
					maskFirst_r <= maskFirst_r;
				end
			endcase
		end
	end

	// read multiplexer; unmapped offsets answer zero
	always @* begin
		case (regAddr)
			`OFS_HOT_ASSERTION_TIME: rdMux = hotTimeValue;
			`OFS_EVENT_STATUS_FIRST: rdMux = statusFirst;
			`OFS_EVENT_STATUS_SECOND: rdMux = statusSecond;
			`OFS_EVENT_MASK_FIRST: rdMux = maskFirst_r;
			`OFS_EVENT_MASK_SECOND: rdMux = maskSecond_r;
			`OFS_HOT_TIME_LIMIT: rdMux = hotLimit_r;
			default: rdMux = 8'h00;
		endcase
	end

	// read data registered; it shows the value from before the read's clear
	// a flag set in the reading cycle is missing here; the next read shows it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= rdMux;
		end
	end

	// mask gates alert
	// flags still record; only the active-low alert level is masked
	// registered so the pin does not glitch while flags settle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alertN <= 1'b1;
		end else begin
			alertN <= ~(|((statusFirst & ~maskFirst_r) |
				(statusSecond & ~maskSecond_r)));
		end
	end
endmodule

// File: hotflag_consts.vh
// constants for the hot-time timer and event status block
`ifndef HOTFLAG_CONSTS_VH
`define HOTFLAG_CONSTS_VH

// register offsets
`define OFS_HOT_ASSERTION_TIME 8'h0F
`define OFS_EVENT_STATUS_FIRST 8'h10
`define OFS_EVENT_STATUS_SECOND 8'h11
`define OFS_EVENT_MASK_FIRST 8'h12
`define OFS_EVENT_MASK_SECOND 8'h13
`define OFS_HOT_TIME_LIMIT 8'h1E

// reset values
`define RST_HOT_ASSERTION_TIME 8'h00
`define RST_EVENT_STATUS 8'h00
`define RST_EVENT_MASK 8'h00
`define RST_HOT_TIME_LIMIT 8'h00

// first status register fields
`define S1_SECOND_FAN 0
`define S1_FIRST_FAN 1
`define S1_LOCAL 2
`define S1_FIRST_REMOTE 3
`define S1_SUPPLY 4
`define S1_SECOND_ANALOG 5
`define S1_FIRST_ANALOG 6
`define S1_SUMMARY 7

// second status register fields
`define S2_OVERTEMP 0
`define S2_HOT_TIME 1
`define S2_FIRST_DIODE 2
`define S2_SECOND_DIODE 3
`define S2_FIRST_THERMISTOR 4
`define S2_SECOND_THERMISTOR 5

// timing: clock period in ns, times in us
`define CLOCK_PERIOD_NS 10
`define HOT_TICK_US 22760
`define HOT_REPORT_US 45520
`define HOT_TICK_CYCLES (`HOT_TICK_US * 1000 / `CLOCK_PERIOD_NS)
`define HOT_REPORT_TICKS (`HOT_REPORT_US / `HOT_TICK_US)

`endif

// File: hot_tick_divider.v
// divider that pulses once per duration step while the hot input is held
`timescale 1ns/1ps
`include "hotflag_consts.vh"
module hot_tick_divider #(
	parameter CYCLES = `HOT_TICK_CYCLES,
	parameter WIDTH = 22
) (
	input wire clock,
	input wire rst_n,
	input wire run,
	output reg tick
);
	// end count cut to the counter width on purpose; CYCLES must fit WIDTH
	localparam integer LAST_INT = CYCLES - 1;
	localparam [WIDTH-1:0] LAST = LAST_INT[WIDTH-1:0];
	reg [WIDTH-1:0] count_r;

	// restarts whenever run drops, so each assertion is timed from its start
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (!run) begin
			count_r <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (count_r == LAST) begin
			count_r <= {WIDTH{1'b0}};
			tick <= 1'b1;
		end else begin
			count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end
endmodule

// File: sticky_flag_cell.v
// one sticky status flag with conditional clear on read
`timescale 1ns/1ps
module sticky_flag_cell (
	input wire clock,
	input wire rst_n,
	input wire setEvent,
	input wire clearRead,
	input wire holdCond,
	output reg flag
);
	// a set in the clearing cycle wins; a live condition blocks the clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else begin
			flag <= setEvent | (flag & ~(clearRead & ~holdCond));
		end
	end
endmodule

// File: reg_host.sv
// host model that issues register reads and writes
`timescale 1ns/1ps
module reg_host (
	input wire clock,
	input wire [7:0] regRdData,
	output reg [7:0] regAddr,
	output reg regRdEn,
	output reg regWrEn,
	output reg [7:0] regWrData
);
	// idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regRdEn = 1'b0;
		regWrEn = 1'b0;
		regWrData = 8'h00;
	end
	// one-cycle strobe; address scrambled after release so stale values never match
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clock) #1;
			regAddr = a;
			regRdEn = 1'b1;
			@(posedge clock) #1;
			regRdEn = 1'b0;
			regAddr = ~a;
			d = regRdData;
		end
	endtask
	// write strobe with data held alongside
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clock) #1;
			regAddr = a;
			regWrData = v;
			regWrEn = 1'b1;
			@(posedge clock) #1;
			regWrEn = 1'b0;
			regAddr = ~a;
			regWrData = ~v;
		end
	endtask
endmodule

// File: hotflag_timer_and_status_sva.sv
// port assertions for the hot timer and event status block
`timescale 1ns/1ps
module hotflag_timer_and_status_sva (
	input wire clock,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire regRdEn,
	input wire [7:0] regRdData,
	input wire firstFanSlow,
	input wire firstFanDriveOff,
	input wire localOutOfLimit,
	input wire firstRemoteOutOfLimit,
	input wire supplyOutOfLimit,
	input wire secondAnalogOutOfLimit,
	input wire firstAnalogOutOfLimit,
	input wire overtempExceeded,
	input wire overtempBelowHyst,
	input wire firstDiodeFault,
	input wire secondDiodeFault,
	input wire firstThermistorFault,
	input wire secondThermistorFault
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// cause vectors in register bit order
	wire [4:0] limitVec = {firstAnalogOutOfLimit, secondAnalogOutOfLimit, supplyOutOfLimit,
		firstRemoteOutOfLimit, localOutOfLimit};
	wire [3:0] faultVec = {secondThermistorFault, firstThermistorFault, secondDiodeFault,
		firstDiodeFault};
	sequence s_rd10; regRdEn && regAddr == 8'h10; endsequence
	sequence s_rd11; regRdEn && regAddr == 8'h11; endsequence
	property p_unused; s_rd11 |=> regRdData[7:6] == 2'b00; endproperty
	a_unused: assert property (p_unused) else $error("unused bits set");
	property p_ovtSet; s_rd11 ##0 $past(overtempExceeded) |=> regRdData[0]; endproperty
	a_ovtSet: assert property (p_ovtSet) else $error("overtemp flag missing");
	property p_ovtClr;
		s_rd11 ##0 $past(overtempBelowHyst && !overtempExceeded) |=> !regRdData[0];
	endproperty
	a_ovtClr: assert property (p_ovtClr) else $error("overtemp flag kept");
	property p_fan; s_rd10 ##0 $past(firstFanSlow && !firstFanDriveOff) |=> regRdData[1]; endproperty
	a_fan: assert property (p_fan) else $error("fan flag missing");
	property p_lim;
		s_rd10 |=> (regRdData[6:2] & $past(limitVec, 2)) == $past(limitVec, 2);
	endproperty
	a_lim: assert property (p_lim) else $error("limit flag missing");
	property p_keep;
		s_rd10 ##0 (localOutOfLimit && $past(localOutOfLimit)) ##2 s_rd10 |=> regRdData[2];
	endproperty
	a_keep: assert property (p_keep) else $error("limit flag lost on read");
	property p_flt;
		s_rd11 |=> (regRdData[5:2] & $past(faultVec, 2)) == $past(faultVec, 2);
	endproperty
	a_flt: assert property (p_flt) else $error("fault flag missing");
	// a stall present during a clearing read must still show at the next read
	property p_race;
		s_rd10 ##0 (firstFanSlow && !firstFanDriveOff) ##1 (!firstFanSlow && !regRdEn)
			##1 s_rd10 |=> regRdData[1];
	endproperty
	a_race: assert property (p_race) else $error("flag lost to clearing read");
	// read data must hold between reads
	property p_stand; !regRdEn |=> $stable(regRdData); endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
endmodule
bind hotflag_timer_and_status hotflag_timer_and_status_sva i_sva (.clock, .rst_n, .regAddr,
	.regRdEn, .regRdData, .firstFanSlow, .firstFanDriveOff, .localOutOfLimit,
	.firstRemoteOutOfLimit, .supplyOutOfLimit, .secondAnalogOutOfLimit, .firstAnalogOutOfLimit,
	.overtempExceeded, .overtempBelowHyst, .firstDiodeFault, .secondDiodeFault,
	.firstThermistorFault, .secondThermistorFault);

// File: tb_top.sv
// self-checking bench for the hot timer and event status block
`timescale 1ns/1ps
module tb_top;
	reg clock = 1'b0, rst_n = 1'b0, processorHotInputN = 1'b1, hotPinIsInput = 1'b0;
	reg firstFanSlow = 1'b0, secondFanSlow = 1'b0, firstFanDriveOff = 1'b0, secondFanDriveOff = 1'b0;
	reg localOutOfLimit = 1'b0, firstRemoteOutOfLimit = 1'b0, supplyOutOfLimit = 1'b0;
	reg secondAnalogOutOfLimit = 1'b0, firstAnalogOutOfLimit = 1'b0;
	reg overtempExceeded = 1'b0, overtempBelowHyst = 1'b0;
	reg firstDiodeFault = 1'b0, secondDiodeFault = 1'b0;
	reg firstThermistorFault = 1'b0, secondThermistorFault = 1'b0;
	wire [7:0] regAddr, regWrData, regRdData;
	wire regRdEn, regWrEn, alertN;
	integer failures = 0, n_tests = 0, cyc = 0;
	reg [7:0] d;
	// 100 MHz clock
	initial begin
		forever #5 clock = ~clock;
	end
	// short tick so the full count range fits in a brief run
	hotflag_timer_and_status #(.TICK_CYCLES(10), .TICK_WIDTH(22)) i_hotflag_timer_and_status (
		.clock, .rst_n, .regAddr, .regRdEn, .regWrEn, .regWrData, .regRdData,
		.processorHotInputN, .hotPinIsInput, .firstFanSlow, .secondFanSlow, .firstFanDriveOff,
		.secondFanDriveOff, .localOutOfLimit, .firstRemoteOutOfLimit, .supplyOutOfLimit,
		.secondAnalogOutOfLimit, .firstAnalogOutOfLimit, .overtempExceeded, .overtempBelowHyst,
		.firstDiodeFault, .secondDiodeFault, .firstThermistorFault, .secondThermistorFault, .alertN);
	reg_host i_reg_host (.clock, .regRdData, .regAddr, .regRdEn, .regWrEn, .regWrData);
	task chk(input [7:0] e);
		begin
			n_tests = n_tests + 1;
			if (d !== e) begin
				failures = failures + 1;
				$display("[FAIL] %0t got %h want %h", $time, d, e);
			end
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			i_reg_host.rd(a, d);
			chk(e);
		end
	endtask
	task wt(input integer n);
		begin
			repeat (n) @(posedge clock);
			#1;
		end
	endtask
	task test_done;
		begin
			if (failures == 0 && n_tests > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// hang guard: the run needs about 2800 cycles
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			$display("[FAIL] %0t timeout", $time);
			failures = failures + 1;
			test_done;
		end
	end
	initial begin
		wt(4);
		rst_n = 1'b1;
		rc(8'h0F, 8'h00);
		rc(8'h10, 8'h00);
		rc(8'h11, 8'h00);
		rc(8'h00, 8'h00);
		i_reg_host.wr(8'h0F, 8'hFF);
		i_reg_host.wr(8'h13, 8'hFF);
		i_reg_host.wr(8'h12, 8'hFF);
		rc(8'h13, 8'h3F);
		// masked faults still latch but keep the alert quiet
		{firstDiodeFault, secondDiodeFault, firstThermistorFault, secondThermistorFault} = 4'hF;
		wt(3);
		d = {7'h00, alertN};
		chk(8'h01);
		rc(8'h10, 8'h80);
		rc(8'h11, 8'h3C);
		rc(8'h11, 8'h3C);
		i_reg_host.wr(8'h12, 8'h00);
		i_reg_host.wr(8'h13, 8'h00);
		wt(2);
		d = {7'h00, alertN};
		chk(8'h00);
		{firstDiodeFault, secondDiodeFault, firstThermistorFault, secondThermistorFault} = 4'h0;
		rc(8'h11, 8'h3C);
		rc(8'h11, 8'h00);
		// second fan drive off hides its stall; limits clear only once gone
		{firstFanSlow, secondFanSlow, secondFanDriveOff} = 3'h7;
		{firstAnalogOutOfLimit, secondAnalogOutOfLimit, supplyOutOfLimit} = 3'h7;
		{firstRemoteOutOfLimit, localOutOfLimit} = 2'h3;
		rc(8'h10, 8'h7E);
		{firstFanSlow, secondFanSlow, secondFanDriveOff} = 3'h0;
		{firstAnalogOutOfLimit, secondAnalogOutOfLimit, supplyOutOfLimit} = 3'h0;
		firstRemoteOutOfLimit = 1'b0;
		rc(8'h10, 8'h7E);
		rc(8'h10, 8'h04);
		rc(8'h10, 8'h04);
		localOutOfLimit = 1'b0;
		rc(8'h10, 8'h04);
		rc(8'h10, 8'h00);
		// over-temperature survives reads, clears below hysteresis
		overtempExceeded = 1'b1;
		wt(2);
		overtempExceeded = 1'b0;
		rc(8'h11, 8'h01);
		rc(8'h11, 8'h01);
		overtempBelowHyst = 1'b1;
		rc(8'h11, 8'h00);
		overtempBelowHyst = 1'b0;
		// hot input ignored while pin is not an input
		i_reg_host.wr(8'h1E, 8'h03);
		processorHotInputN = 1'b0;
		rc(8'h0F, 8'h00);
		rc(8'h11, 8'h00);
		hotPinIsInput = 1'b1;
		rc(8'h0F, 8'h01);
		rc(8'h0F, 8'h00);
		wt(40);
		processorHotInputN = 1'b1;
		rc(8'h0F, 8'h04);
		rc(8'h11, 8'h02);
		rc(8'h11, 8'h00);
		// zero limit flags at once; ten steps of ten cycles read 0x0A; long run saturates
		i_reg_host.wr(8'h1E, 8'h00);
		processorHotInputN = 1'b0;
		rc(8'h11, 8'h02);
		wt(98);
		rc(8'h0F, 8'h0A);
		wt(2600);
		processorHotInputN = 1'b1;
		rc(8'h0F, 8'hFF);
		test_done;
	end
endmodule
